// file: verilog/dsb_cfg.svh
// Address map, reset values and sizes for the descriptor slot bitmaps
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH
`define DSB_SLOTS 32
`define DSB_ADDR_W 16
`define DSB_OFS_ISO_DONE 16'h0130
`define DSB_OFS_ISO_BYPASS 16'h0134
`define DSB_OFS_ISO_FINAL 16'h0138
`define DSB_OFS_INTR_DONE 16'h0140
`define DSB_OFS_INTR_BYPASS 16'h0144
`define DSB_OFS_INTR_FINAL 16'h0148
`define DSB_OFS_ASYNC_DONE 16'h0150
`define DSB_OFS_ASYNC_BYPASS 16'h0154
`define DSB_OFS_ASYNC_FINAL 16'h0158
`define DSB_RST_DONE 32'h0000_0000
`define DSB_RST_BYPASS 32'hffff_ffff
`define DSB_RST_FINAL 32'h0000_0000
`define DSB_SLOT_MAX 5'h1f
`endif

// file: verilog/dsb_pkg.sv
// Types shared by the descriptor slot bitmap block
package dsb_pkg;
   typedef logic [31:0] dsb_map_t;
   typedef logic [4:0] dsb_slot_t;
   // Scanner states, Gray coded along idle -> check -> wrap
   typedef enum logic [1:0] {
      DSB_IDLE = 2'b00,
      DSB_CHECK = 2'b01,
      DSB_WRAP = 2'b11
   } dsb_scan_e;
endpackage

// file: verilog/dsb_scan_if.sv
// Carrier between the register bank and one category scanner
`timescale 1ns/1ps
interface dsb_scan_if;
   logic [31:0] bypass_map; // Slots excluded from the scan
   logic [31:0] final_map; // One-hot end of scan
   logic [31:0] valid_map; // Slot valid flags from descriptor memory
   logic run; // Scanning allowed
   logic pick; // Slot offered this cycle
   logic [4:0] pick_slot; // Which slot is offered
   logic wrapped; // Scan restarted at slot 0
   modport bank (output bypass_map, output final_map, output valid_map, output run,
                 input pick, input pick_slot, input wrapped);
   modport scan (input bypass_map, input final_map, input valid_map, input run,
                 output pick, output pick_slot, output wrapped);
endinterface

// file: verilog/dsb_scanner.sv
// Slot scanner for one descriptor category
`timescale 1ns/1ps
`include "dsb_cfg.svh"
module dsb_scanner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Map and scheduling carrier
   dsb_scan_if.scan sif
);
   dsb_pkg::dsb_scan_e state_ff, nxt_state; // Scanner state
   dsb_pkg::dsb_slot_t slot_ff, nxt_slot; // Slot being examined
   logic pick_ff, nxt_pick; // Offer strobe
   logic wrap_ff, nxt_wrap; // Wrap strobe
   logic at_end; // Current slot ends the scan

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Walk one slot per cycle; never look at pointers inside slots
   always_comb begin
      nxt_state = state_ff;
      nxt_slot = slot_ff;
      nxt_pick = 1'b0;
      nxt_wrap = 1'b0;
      // No final bit set means the whole category is scanned
      at_end = sif.final_map[slot_ff] || (slot_ff == `DSB_SLOT_MAX);
      case (state_ff)
         dsb_pkg::DSB_IDLE: begin
            nxt_slot = 5'h00;
            if (sif.run) begin
               nxt_state = dsb_pkg::DSB_CHECK;
            end
         end
         dsb_pkg::DSB_CHECK: begin
            // Skipped slots are passed over even when valid
            nxt_pick = sif.valid_map[slot_ff] && !sif.bypass_map[slot_ff];
            if (!sif.run) begin
               nxt_state = dsb_pkg::DSB_IDLE;
            end else if (at_end) begin
               nxt_state = dsb_pkg::DSB_WRAP;
            end else begin
               nxt_slot = slot_ff + 5'h01;
            end
         end
         dsb_pkg::DSB_WRAP: begin
            // Restart from slot 0 of this category
            nxt_slot = 5'h00;
            nxt_wrap = 1'b1;
            nxt_state = sif.run ? dsb_pkg::DSB_CHECK : dsb_pkg::DSB_IDLE;
         end
         default: begin
            nxt_state = dsb_pkg::DSB_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dsb_pkg::DSB_IDLE;
         slot_ff <= 5'h00;
         pick_ff <= 1'b0;
         wrap_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         slot_ff <= nxt_slot;
         pick_ff <= nxt_pick;
         wrap_ff <= nxt_wrap;
      end
   end

   // Pick strobe names the slot examined in the previous cycle
   dsb_pkg::dsb_slot_t pslot_ff, nxt_pslot; // Slot of the offer
   always_comb begin
      nxt_pslot = slot_ff;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pslot_ff <= 5'h00;
      end else begin
         pslot_ff <= nxt_pslot;
      end
   end

   assign sif.pick = pick_ff;
   assign sif.pick_slot = pslot_ff;
   assign sif.wrapped = wrap_ff;
endmodule // dsb_scanner

// file: verilog/dsb_slot_maps.sv
// Done, bypass and final slot bitmaps for three descriptor categories
`timescale 1ns/1ps
`include "dsb_cfg.svh"
// ---------------------------------------------------------------
// Functional notes
// - Completion sets the slot's done bit
// - Done read returns bits, then clears them
// - Done maps read-only, reset to zero
// - Bypassed slot never processed, even valid
// - Bypassed slot pointer ignored for ordering
// - Bypass maps read-write, reset all ones
// - Final bit marks last examined slot
// - After final slot, scan restarts at 0
// - Final maps read-write, reset zero
// - Final map one-hot, 1h is slot 0
// ---------------------------------------------------------------
module dsb_slot_maps (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Processor register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Completion events per category, one bit per slot, pulses
   input wire logic [31:0] iso_done_evt,
   input wire logic [31:0] intr_done_evt,
   input wire logic [31:0] async_done_evt,
   // Valid flags of slots from descriptor memory
   input wire logic [31:0] iso_valid,
   input wire logic [31:0] intr_valid,
   input wire logic [31:0] async_valid,
   // Scheduler enable
   input wire logic sched_run,
   // Slot offers to the scheduling engine, index 0 iso, 1 intr, 2 async
   output logic [2:0] slot_pick,
   output logic [14:0] slot_pick_idx,
   output logic [2:0] scan_wrapped
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_ff, rst_sync_ff; // Two-stage release of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Map registers
   // ---------------------------------------------------------------
   dsb_pkg::dsb_map_t done_ff [3]; // Completed slots per category
   dsb_pkg::dsb_map_t bypass_ff [3]; // Bypassed slots per category
   dsb_pkg::dsb_map_t final_ff [3]; // Final slot marker per category
   dsb_pkg::dsb_map_t nxt_done [3];
   dsb_pkg::dsb_map_t nxt_bypass [3];
   dsb_pkg::dsb_map_t nxt_final [3];
   logic [31:0] rdata_ff, nxt_rdata; // Registered read data
   logic [31:0] evt [3]; // Completion events by category
   logic [15:0] ofs_done [3]; // Done map offsets
   logic [15:0] ofs_bypass [3]; // Bypass map offsets
   logic [15:0] ofs_final [3]; // Final map offsets

   assign evt[0] = iso_done_evt;
   assign evt[1] = intr_done_evt;
   assign evt[2] = async_done_evt;
   assign ofs_done[0] = `DSB_OFS_ISO_DONE;
   assign ofs_done[1] = `DSB_OFS_INTR_DONE;
   assign ofs_done[2] = `DSB_OFS_ASYNC_DONE;
   assign ofs_bypass[0] = `DSB_OFS_ISO_BYPASS;
   assign ofs_bypass[1] = `DSB_OFS_INTR_BYPASS;
   assign ofs_bypass[2] = `DSB_OFS_ASYNC_BYPASS;
   assign ofs_final[0] = `DSB_OFS_ISO_FINAL;
   assign ofs_final[1] = `DSB_OFS_INTR_FINAL;
   assign ofs_final[2] = `DSB_OFS_ASYNC_FINAL;

   // Decode and next values; unmapped reads return zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      for (int c = 0; c < 3; c++) begin
         nxt_done[c] = done_ff[c];
         nxt_bypass[c] = bypass_ff[c];
         nxt_final[c] = final_ff[c];
         if (reg_rd && reg_addr == ofs_done[c]) begin
            nxt_rdata = done_ff[c];
            nxt_done[c] = 32'h0000_0000;
         end
         if (reg_rd && reg_addr == ofs_bypass[c]) begin
            nxt_rdata = bypass_ff[c];
         end
         if (reg_rd && reg_addr == ofs_final[c]) begin
            nxt_rdata = final_ff[c];
         end
         // Done maps ignore writes
         if (reg_wr && reg_addr == ofs_bypass[c]) begin
            nxt_bypass[c] = reg_wdata;
         end
         if (reg_wr && reg_addr == ofs_final[c]) begin
            nxt_final[c] = reg_wdata;
         end
         // Set after clear, so a completion in the read cycle is kept
         nxt_done[c] = nxt_done[c] | evt[c];
      end
   end

   // Register the maps
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         for (int c = 0; c < 3; c++) begin
            done_ff[c] <= `DSB_RST_DONE;
            bypass_ff[c] <= `DSB_RST_BYPASS;
            final_ff[c] <= `DSB_RST_FINAL;
         end
         rdata_ff <= 32'h0000_0000;
      end else begin
         for (int c = 0; c < 3; c++) begin
            done_ff[c] <= nxt_done[c];
            bypass_ff[c] <= nxt_bypass[c];
            final_ff[c] <= nxt_final[c];
         end
         rdata_ff <= nxt_rdata;
      end
   end
   assign reg_rdata = rdata_ff;

   // ---------------------------------------------------------------
   // Category scanners
   // ---------------------------------------------------------------
   // Pointers inside slots are never read, so ordering is by index only
   dsb_scan_if sif [3] ();
   assign sif[0].valid_map = iso_valid;
   assign sif[1].valid_map = intr_valid;
   assign sif[2].valid_map = async_valid;
   for (genvar g = 0; g < 3; g++) begin : g_cat
      assign sif[g].bypass_map = bypass_ff[g];
      assign sif[g].final_map = final_ff[g];
      assign sif[g].run = sched_run;
      dsb_scanner u_scan (
         .clk(clk),
         .rst_n(rst_sync_ff),
         .sif(sif[g].scan)
      );
      assign slot_pick[g] = sif[g].pick;
      assign slot_pick_idx[g*5 +: 5] = sif[g].pick_slot;
      assign scan_wrapped[g] = sif[g].wrapped;
   end
endmodule // dsb_slot_maps

// file: test/dsb_slot_maps_props.sv
// Port-level checks for the descriptor slot bitmaps
`timescale 1ns/1ps
`include "dsb_cfg.svh"
module dsb_slot_maps_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Events, valid flags and scanner offers
   input wire logic [31:0] iso_done_evt,
   input wire logic [31:0] intr_done_evt,
   input wire logic [31:0] async_done_evt,
   input wire logic [31:0] iso_valid,
   input wire logic [31:0] intr_valid,
   input wire logic [2:0] slot_pick,
   input wire logic [14:0] slot_pick_idx,
   input wire logic [2:0] scan_wrapped
);
   // Valid flags of the cycle in which the offered slot was examined
   logic [63:0] vq_ff;
   logic [63:0] nxt_vq;
   always_comb nxt_vq = {intr_valid, iso_valid};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) vq_ff <= '0;
      else vq_ff <= nxt_vq;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_DONE_SET: assert property (
      (intr_done_evt != 32'h0) ##1 (reg_rd && reg_addr == `DSB_OFS_INTR_DONE)
      |=> (reg_rdata & $past(intr_done_evt, 2)) == $past(intr_done_evt, 2)) else $error("set lost");
   AST_DONE_CLR: assert property (
      (reg_rd && reg_addr == `DSB_OFS_ISO_DONE && iso_done_evt == 32'h0)
      ##1 (reg_rd && reg_addr == `DSB_OFS_ISO_DONE) |=> reg_rdata == 32'h0) else $error("not cleared");
   AST_DONE_KEEP: assert property (
      (reg_rd && reg_addr == `DSB_OFS_ASYNC_DONE) ##1 (reg_rd && reg_addr == `DSB_OFS_ASYNC_DONE)
      |=> (reg_rdata & $past(async_done_evt, 2)) == $past(async_done_evt, 2)) else $error("lost");
   AST_PICK_ISO: assert property (
      slot_pick[0] |-> vq_ff[slot_pick_idx[4:0]]) else $error("iso offer not valid");
   AST_PICK_INTR: assert property (
      slot_pick[1] |-> vq_ff[32 + slot_pick_idx[9:5]]) else $error("intr offer not valid");
   AST_WRAP_PULSE: assert property (
      scan_wrapped[0] |=> !scan_wrapped[0]) else $error("wrap held");
   AST_BYPASS_RW: assert property (
      (reg_wr && reg_addr == `DSB_OFS_ISO_BYPASS) ##1 (reg_rd && reg_addr == `DSB_OFS_ISO_BYPASS)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("bypass lost");
   AST_FINAL_RW: assert property (
      (reg_wr && reg_addr == `DSB_OFS_INTR_FINAL) ##1 (reg_rd && reg_addr == `DSB_OFS_INTR_FINAL)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("final lost");
   // Main scenarios reached
   cover property (slot_pick[0] ##1 scan_wrapped[0]);
   cover property (reg_rd && reg_addr == `DSB_OFS_ASYNC_DONE ##1 reg_rd);
   cover property (slot_pick[2] && slot_pick_idx[14:10] == 5'h01);
endmodule // dsb_slot_maps_props
bind dsb_slot_maps dsb_slot_maps_props i_props (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .iso_done_evt(iso_done_evt),
   .intr_done_evt(intr_done_evt), .async_done_evt(async_done_evt), .iso_valid(iso_valid),
   .intr_valid(intr_valid), .slot_pick(slot_pick), .slot_pick_idx(slot_pick_idx),
   .scan_wrapped(scan_wrapped));

// file: test/tb_descriptor_slot_bitmaps.sv
// Self-checking bench for the descriptor slot bitmaps
`timescale 1ns/1ps
module tb_descriptor_slot_bitmaps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic [31:0] evt [3] = '{default: 32'h0};
   logic [31:0] vld = 32'h0000_00ff; // Slots 0 to 7 hold work
   logic sched_run = 1'b0;
   logic [2:0] slot_pick;
   logic [14:0] slot_pick_idx;
   logic [2:0] scan_wrapped;
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] seen [3]; // Slots offered per category
   logic wrapped [3]; // Wrap seen, next offer still pending
   logic [2:0] wrap_seen = 3'h0; // Any wrap seen per category
   // Expected footprint and first slot after a wrap, per category
   logic [31:0] exp_seen [3] = '{32'h0000_001a, 32'h0000_0001, 32'h0000_0003};
   logic [4:0] exp_first [3] = '{5'h01, 5'h00, 5'h00};
   dsb_slot_maps i_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .iso_done_evt(evt[0]),
      .intr_done_evt(evt[1]), .async_done_evt(evt[2]), .iso_valid(vld), .intr_valid(vld),
      .async_valid(vld), .sched_run(sched_run), .slot_pick(slot_pick),
      .slot_pick_idx(slot_pick_idx), .scan_wrapped(scan_wrapped));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ----------------------------------------
   // Access tasks; strobes stay up so reads run back to back
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] ofs(input int c, input int r);
      return 16'h0130 + 16'(c * 16 + r * 4);
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic idle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // Internal reset copy needs two edges before the first request
      repeat (2) @(posedge clk);
      #1;
      for (int i = 0; i < 9; i++) begin
         rd(ofs(i / 3, i % 3), (i % 3 == 1) ? 32'hffff_ffff : 32'h0);
      end
      // Done maps ignore writes; the other maps store them
      for (int c = 0; c < 3; c++) begin
         wr(ofs(c, 0), 32'hffff_ffff);
         rd(ofs(c, 0), 32'h0);
         wr(ofs(c, 1), 32'h5a5a_0000 | 32'(c));
         rd(ofs(c, 1), 32'h5a5a_0000 | 32'(c));
         wr(ofs(c, 2), 32'h8000_0000 >> c);
         rd(ofs(c, 2), 32'h8000_0000 >> c);
      end
      // Completion, then one landing on the clearing read itself
      for (int c = 0; c < 3; c++) begin
         evt[c] = 32'h8000_0001;
         idle();
         evt[c] = 32'h0000_0100;
         rd(ofs(c, 0), 32'h8000_0001);
         evt[c] = 32'h0;
         rd(ofs(c, 0), 32'h0000_0100);
         rd(ofs(c, 0), 32'h0);
      end
      // Bypass slots 0 and 2 of iso; final slot 4, 0 and 1 per category
      for (int c = 0; c < 3; c++) begin
         wr(ofs(c, 1), (c == 0) ? 32'h0000_0005 : 32'h0);
         wr(ofs(c, 2), (c == 0) ? 32'h0000_0010 : 32'h1 << (c - 1));
      end
      idle();
      sched_run = 1'b1;
      seen = '{default: 32'h0};
      wrapped = '{default: 1'b0};
      repeat (80) begin
         @(posedge clk);
         #1;
         for (int c = 0; c < 3; c++) begin
            if (slot_pick[c] === 1'b1) begin
               seen[c][slot_pick_idx[c * 5 +: 5]] = 1'b1;
               if (wrapped[c]) begin
                  chk(32'(slot_pick_idx[c * 5 +: 5]), 32'(exp_first[c]));
                  wrapped[c] = 1'b0;
               end
            end
            if (scan_wrapped[c] === 1'b1) begin
               wrapped[c] = 1'b1;
               wrap_seen[c] = 1'b1;
            end
         end
      end
      for (int c = 0; c < 3; c++) chk(seen[c], exp_seen[c]);
      // Without a wrap the first-slot check above never runs
      chk(32'(wrap_seen), 32'h0000_0007);
      sched_run = 1'b0;
      final_report();
   end
endmodule // tb_descriptor_slot_bitmaps
